/* hw/qss_core.sv */
// queued serial port: slave transfers, wraparound queue, master chip-select drive
`timescale 1ns/1ps
`default_nettype none
`include "qss_defines.svh"
module qss_core #(
	parameter int DEPTH = 16,
	parameter int MASTER_HALF = `QSS_MASTER_HALF,
	localparam int QW = $clog2(DEPTH)
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic masterSelect,
	input wire logic clockPolarity,
	input wire logic clockPhase,
	input wire logic [3:0] transferBits,
	input wire logic wrapEnable,
	input wire logic wrapTargetSelect,
	input wire logic haltRequest,
	input wire logic queueDoneIrqEnable,
	input wire logic [3:0] portDirection,
	input wire logic portValueWrite,
	input wire logic [3:0] portValueData,
	input wire logic runEnableSet,
	input wire logic runEnableClear,
	input wire logic doneFlagClear,
	input wire logic modeFaultClear,
	input wire logic newQpWrite,
	input wire logic [QW-1:0] newQpData,
	input wire logic [QW-1:0] endQueuePointer,
	input wire logic txWrite,
	input wire logic [QW-1:0] txAddr,
	input wire logic [15:0] txData,
	input wire logic cmdWrite,
	input wire logic [QW-1:0] cmdAddr,
	input wire qss_pkg::qss_cmd_s cmdData,
	input wire logic [QW-1:0] rxAddr,
	output logic [15:0] rxData,
	input wire logic sckIn,
	input wire logic mosiIn,
	input wire logic misoIn,
	input wire logic slaveSelectIn,
	output qss_pkg::qss_pins_s pinOut,
	output qss_pkg::qss_pins_s pinOe,
	output logic queueRunEnable,
	output logic queueDoneFlag,
	output logic irqRequest,
	output logic modeFault,
	output logic haltAck,
	output logic [QW-1:0] completedQueuePointer,
	output logic [QW-1:0] newQueuePointer
);
	logic [15:0] txRam [DEPTH];
	logic [15:0] rxRam [DEPTH];
	qss_pkg::qss_cmd_s cmdRam [DEPTH];
	qss_pkg::qss_state_e state;
	qss_pkg::qss_cmd_s activeCmd;
	logic [3:0] pinSync;
	logic sckPrev;
	logic [15:0] shiftReg;
	logic [4:0] bitCnt;
	logic [4:0] activeLen;
	logic [QW-1:0] workPtr;
	logic qpPending;
	logic [3:0] portValue;
	logic sckActive;
	logic [7:0] halfCnt;

	// pins are asynchronous to sys_clk, so the slave clock must run well below it
	qss_sync #(.WIDTH(4), .RESET_VAL(`QSS_PIN_SYNC_RESET)) uPinSync (
		.sys_clk(sys_clk),
		.rst(rst),
		.asyncIn({slaveSelectIn, sckIn, mosiIn, misoIn}),
		.syncOut(pinSync)
	);

	logic ssS, sckS, mosiS, misoS;
	assign ssS = pinSync[3];
	assign sckS = pinSync[2];
	assign mosiS = pinSync[1];
	assign misoS = pinSync[0];

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sckPrev <= 1'b0;
		end else begin
			sckPrev <= sckS;
		end
	end

	function automatic logic [4:0] decodeLen(input logic [3:0] code);
		if (code == `QSS_LEN_CODE_MAX) begin
			return `QSS_LEN_MAX;
		end else if (code[3]) begin
			return {1'b0, code};
		end
		// reserved codes fall back to the default length
		return `QSS_LEN_DEFAULT;
	endfunction

	logic leadEdge, trailEdge, slaveSample, tick, capNow;
	logic sLast, mLast, wordDone, queueEnd, continueAfter;
	logic startSlave, startMaster;
	logic [4:0] slaveLen;
	logic [3:0] msbIdx;
	logic [16:0] maskWide;
	logic [15:0] finalWord;
	logic [QW-1:0] advPtr, wrapPtr, nextPtr, startPtr;

	assign leadEdge = (sckS ^ clockPolarity) & ~(sckPrev ^ clockPolarity);
	assign trailEdge = ~(sckS ^ clockPolarity) & (sckPrev ^ clockPolarity);
	assign slaveSample = clockPhase ? trailEdge : leadEdge;
	assign tick = (halfCnt == 8'(MASTER_HALF - 1));
	assign capNow = tick && (clockPhase ? sckActive : !sckActive);
	assign slaveLen = decodeLen(transferBits);
	assign msbIdx = 4'(activeLen - 5'h01);
	assign maskWide = (17'h00001 << activeLen) - 17'h00001;

	// one bit per sampled clock edge while selected; the length-th bit closes the word
	assign sLast = (state == qss_pkg::QS_SLAVE) && slaveSample && !ssS
		&& (bitCnt == activeLen - 5'h01);
	assign mLast = (state == qss_pkg::QS_MSHIFT) && tick && sckActive
		&& (clockPhase ? (bitCnt == activeLen - 5'h01) : (bitCnt == activeLen));
	assign wordDone = sLast || mLast;
	assign queueEnd = wordDone && (workPtr == endQueuePointer);
	assign continueAfter = !queueEnd || wrapEnable;

	always_comb begin
		if ((state == qss_pkg::QS_SLAVE) || clockPhase) begin
			finalWord = {shiftReg[14:0], (state == qss_pkg::QS_SLAVE) ? mosiS : misoS}
				& maskWide[15:0];
		end else begin
			finalWord = shiftReg & maskWide[15:0];
		end
	end

	assign advPtr = qpPending ? newQueuePointer : workPtr + QW'(1);
	assign wrapPtr = wrapTargetSelect ? newQueuePointer : QW'(`QSS_QUEUE_BASE);
	assign nextPtr = queueEnd ? (wrapEnable ? wrapPtr : workPtr) : advPtr;
	assign startPtr = qpPending ? newQueuePointer : workPtr;

	// halt blocks new starts; the word already running is left to finish
	assign startSlave = (state == qss_pkg::QS_IDLE) && queueRunEnable && !masterSelect
		&& !ssS && !haltRequest;
	assign startMaster = (state == qss_pkg::QS_IDLE) && queueRunEnable && masterSelect
		&& !modeFault && !haltRequest;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state <= qss_pkg::QS_IDLE;
		end else begin
			case (state)
				qss_pkg::QS_IDLE: begin
					if (startSlave) begin
						state <= qss_pkg::QS_SLAVE;
					end else if (startMaster) begin
						state <= qss_pkg::QS_MSHIFT;
					end
				end
				qss_pkg::QS_SLAVE: begin
					// run clear here can cut a word short, which is why halt is the clean exit
					if (!queueRunEnable || masterSelect || ssS) begin
						state <= qss_pkg::QS_IDLE;
					end else if (sLast && (!continueAfter || haltRequest)) begin
						state <= qss_pkg::QS_IDLE;
					end
				end
				qss_pkg::QS_MSHIFT: begin
					if (!queueRunEnable || modeFault) begin
						state <= qss_pkg::QS_IDLE;
					end else if (mLast) begin
						// the last entry stops at once, so run clear and idle land together
						state <= continueAfter ? qss_pkg::QS_MGAP : qss_pkg::QS_IDLE;
					end
				end
				qss_pkg::QS_MGAP: begin
					if (!queueRunEnable || modeFault) begin
						state <= qss_pkg::QS_IDLE;
					end else if (tick) begin
						state <= haltRequest ? qss_pkg::QS_IDLE : qss_pkg::QS_MSHIFT;
					end
				end
				default: begin
					state <= qss_pkg::QS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			workPtr <= '0;
			qpPending <= 1'b0;
			completedQueuePointer <= '0;
			newQueuePointer <= '0;
		end else begin
			if (newQpWrite) begin
				newQueuePointer <= newQpData;
			end
			// a fresh write in the consuming cycle stays pending for the next entry
			if (newQpWrite || runEnableSet) begin
				qpPending <= 1'b1;
			end else if (startSlave || startMaster || (wordDone && !queueEnd)) begin
				qpPending <= 1'b0;
			end
			if (startSlave || startMaster) begin
				workPtr <= startPtr;
			end else if (wordDone) begin
				workPtr <= nextPtr;
			end
			if (wordDone) begin
				completedQueuePointer <= workPtr;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			halfCnt <= '0;
		end else if ((state == qss_pkg::QS_MSHIFT) || (state == qss_pkg::QS_MGAP)) begin
			halfCnt <= tick ? 8'h00 : halfCnt + 8'h01;
		end else begin
			halfCnt <= '0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			shiftReg <= '0;
			bitCnt <= '0;
			activeLen <= `QSS_LEN_DEFAULT;
			activeCmd <= '0;
			sckActive <= 1'b0;
		end else begin
			case (state)
				qss_pkg::QS_IDLE: begin
					bitCnt <= '0;
					sckActive <= 1'b0;
					if (startSlave) begin
						shiftReg <= txRam[startPtr];
						activeLen <= slaveLen;
					end else if (startMaster) begin
						shiftReg <= txRam[startPtr];
						activeCmd <= cmdRam[startPtr];
						activeLen <= cmdRam[startPtr].lengthSelect ? slaveLen : `QSS_LEN_DEFAULT;
					end
				end
				qss_pkg::QS_SLAVE: begin
					if (sLast) begin
						shiftReg <= txRam[nextPtr];
						bitCnt <= '0;
					end else if (slaveSample && !ssS) begin
						shiftReg <= {shiftReg[14:0], mosiS};
						bitCnt <= bitCnt + 5'h01;
					end
				end
				qss_pkg::QS_MSHIFT: begin
					if (tick) begin
						sckActive <= !sckActive;
					end
					if (capNow) begin
						shiftReg <= {shiftReg[14:0], misoS};
						bitCnt <= bitCnt + 5'h01;
					end
				end
				qss_pkg::QS_MGAP: begin
					bitCnt <= '0;
					sckActive <= 1'b0;
					if (tick) begin
						shiftReg <= txRam[workPtr];
						activeCmd <= cmdRam[workPtr];
						activeLen <= cmdRam[workPtr].lengthSelect ? slaveLen : `QSS_LEN_DEFAULT;
					end
				end
				default: begin
					bitCnt <= '0;
				end
			endcase
		end
	end

	for (genvar i = 0; i < DEPTH; i++) begin : gEntry
		always_ff @(posedge sys_clk) begin
			if (rst) begin
				txRam[i] <= '0;
				rxRam[i] <= '0;
				cmdRam[i] <= '0;
			end else begin
				if (txWrite && (txAddr == QW'(i))) begin
					txRam[i] <= txData;
				end
				if (cmdWrite && (cmdAddr == QW'(i))) begin
					cmdRam[i] <= cmdData;
				end
				// old receive data is simply overwritten on each pass
				if (wordDone && (workPtr == QW'(i))) begin
					rxRam[i] <= finalWord;
				end
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rxData <= '0;
		end else begin
			rxData <= rxRam[rxAddr];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			queueRunEnable <= 1'b0;
			queueDoneFlag <= 1'b0;
			irqRequest <= 1'b0;
			modeFault <= 1'b0;
			haltAck <= 1'b0;
			portValue <= `QSS_PORT_RESET;
		end else begin
			if (runEnableSet) begin
				queueRunEnable <= 1'b1;
			end else if (runEnableClear || (queueEnd && !wrapEnable)) begin
				queueRunEnable <= 1'b0;
			end
			if (queueEnd) begin
				queueDoneFlag <= 1'b1;
			end else if (doneFlagClear) begin
				queueDoneFlag <= 1'b0;
			end
			// the request is latched, so dropping the enable later does not cancel it
			if (queueEnd && queueDoneIrqEnable) begin
				irqRequest <= 1'b1;
			end else if (doneFlagClear) begin
				irqRequest <= 1'b0;
			end
			if (masterSelect && !portDirection[0] && !ssS) begin
				modeFault <= 1'b1;
			end else if (modeFaultClear) begin
				modeFault <= 1'b0;
			end
			haltAck <= haltRequest && (state == qss_pkg::QS_IDLE);
			if (portValueWrite) begin
				portValue <= portValueData;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pinOut <= '0;
			pinOe <= '0;
		end else begin
			pinOut.sck <= clockPolarity ^ sckActive;
			if ((state == qss_pkg::QS_MSHIFT) && (clockPhase ? sckActive : !sckActive)) begin
				pinOut.mosi <= shiftReg[msbIdx];
			end
			if (state == qss_pkg::QS_SLAVE) begin
				pinOut.miso <= shiftReg[msbIdx];
			end
			pinOut.peripheral_select_pattern <= (state == qss_pkg::QS_MSHIFT) ? activeCmd.peripheralSelectPattern
				: portValue;
			pinOe.sck <= masterSelect && !modeFault;
			pinOe.mosi <= masterSelect && !modeFault;
			pinOe.miso <= !masterSelect && (state == qss_pkg::QS_SLAVE);
			pinOe.peripheral_select_pattern <= (masterSelect && !modeFault) ? portDirection : 4'h0;
		end
	end

	default clocking cbMain @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence sPartialRelease;
		(state == qss_pkg::QS_SLAVE) && ssS && (bitCnt != 5'h00);
	endsequence

	sequence sMasterActive;
		(state == qss_pkg::QS_MSHIFT) [*2];
	endsequence

	AST_WRAP_TARGET: assert property (
		queueEnd && wrapEnable |=> workPtr == ($past(wrapTargetSelect) ? $past(newQueuePointer)
			: QW'(`QSS_QUEUE_BASE)))
		else $error("wrap did not land on the selected target");
	AST_WRAP_KEEPS_RUN: assert property (
		queueEnd && wrapEnable && !runEnableClear |=> queueRunEnable && queueDoneFlag)
		else $error("wrapping queue lost run enable");
	AST_DONE_STICKY: assert property (
		queueDoneFlag && !doneFlagClear |=> queueDoneFlag)
		else $error("done flag cleared itself");
	AST_IRQ_BUFFERED: assert property (
		irqRequest && !doneFlagClear && $fell(queueDoneIrqEnable) |=> irqRequest)
		else $error("enable clear withdrew an active request");
	AST_NOWRAP_STOPS: assert property (
		queueEnd && !wrapEnable && !runEnableSet |=> !queueRunEnable && queueDoneFlag
			&& (state == qss_pkg::QS_IDLE))
		else $error("queue did not stop at its end");
	AST_HALT_STOPS: assert property (
		haltRequest && wordDone |=> ##[0:MASTER_HALF] (state == qss_pkg::QS_IDLE))
		else $error("halt did not stop after the word");
	AST_SLAVE_NO_DRIVE: assert property (
		!masterSelect ##1 !masterSelect |-> !pinOe.sck && !pinOe.mosi && (pinOe.peripheral_select_pattern == 4'h0))
		else $error("slave mode drove clock or chip-select");
	AST_WORD_ADVANCE: assert property (
		wordDone && !queueEnd |=> completedQueuePointer == $past(workPtr))
		else $error("completed pointer not updated at word end");
	AST_SHORT_RESTART: assert property (
		sPartialRelease |=> (workPtr == $past(workPtr)) && (state == qss_pkg::QS_IDLE))
		else $error("early release moved the queue pointer");
	AST_PCS_PATTERN: assert property (
		sMasterActive |-> pinOut.peripheral_select_pattern == activeCmd.peripheralSelectPattern)
		else $error("chip-selects differ from command pattern");
	AST_FAULT_SET: assert property (
		masterSelect && !portDirection[0] && !ssS |=> modeFault)
		else $error("select low in master mode gave no fault");
	AST_FAULT_QUIET: assert property (
		modeFault ##1 modeFault |-> !pinOe.sck && (pinOe.peripheral_select_pattern == 4'h0))
		else $error("master outputs driven during mode fault");
endmodule // qss_core
`default_nettype wire

/* hw/qss_defines.svh */
// shared constants of the queued serial slave block: lengths, reset values, counts
`ifndef QSS_DEFINES_SVH
`define QSS_DEFINES_SVH

`define QSS_LEN_DEFAULT 5'h08
`define QSS_LEN_MAX 5'h10
`define QSS_LEN_CODE_MAX 4'h0
`define QSS_PORT_RESET 4'h0
`define QSS_QUEUE_BASE 0
`define QSS_PIN_SYNC_RESET 4'h8
`define QSS_MASTER_HALF 2

`endif

/* hw/qss_pkg.sv */
// types shared by the queued serial slave block
package qss_pkg;

	typedef enum logic [1:0] {QS_IDLE, QS_SLAVE, QS_MSHIFT, QS_MGAP} qss_state_e;

	typedef struct packed {
		logic lengthSelect;
		logic [3:0] peripheralSelectPattern;
	} qss_cmd_s;

	typedef struct packed {
		logic sck;
		logic mosi;
		logic miso;
		logic [3:0] peripheral_select_pattern;
	} qss_pins_s;

endpackage

/* hw/qss_sync.sv */
// two-flop synchroniser for pin inputs, one chain per bit
`timescale 1ns/1ps
`default_nettype none
module qss_sync #(
	parameter int WIDTH = 4,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stageOne;

	for (genvar i = 0; i < WIDTH; i++) begin : gSync
		always_ff @(posedge sys_clk) begin
			if (rst) begin
				stageOne[i] <= RESET_VAL[i];
				syncOut[i] <= RESET_VAL[i];
			end else begin
				stageOne[i] <= asyncIn[i];
				syncOut[i] <= stageOne[i];
			end
		end
	end
endmodule // qss_sync
`default_nettype wire

/* verification/qss_core_test.sv */
// self-checking bench for the queued serial port core
`timescale 1ns/1ps
`default_nettype none
module qss_core_test;
	localparam logic [15:0] TXV [4] = '{16'hc3a5, 16'h5a3c, 16'h96e1, 16'h1e87};
	logic sys_clk = 1'h0, rst = 1'h1, masterSelect = 1'h0, wrapEnable = 1'h0;
	logic wrapTargetSelect = 1'h0, haltRequest = 1'h0, queueDoneIrqEnable = 1'h1;
	logic portValueWrite = 1'h0, runEnableSet = 1'h0, runEnableClear = 1'h0;
	logic doneFlagClear = 1'h0, modeFaultClear = 1'h0, newQpWrite = 1'h0;
	logic txWrite = 1'h0, cmdWrite = 1'h0, sckIn, mosiIn, slaveSelectIn;
	logic [3:0] transferBits = 4'h8, portValueData = 4'h0, newQpData = 4'h0;
	logic [3:0] portDirection = 4'h0;
	logic clockPolarity = 1'h0, clockPhase = 1'h0, misoIn = 1'h0;
	logic [3:0] endQueuePointer = 4'h2, txAddr = 4'h0, cmdAddr = 4'h0, rxAddr = 4'h0;
	logic [15:0] txData = 16'h0, rxData;
	qss_pkg::qss_cmd_s cmdData = '0;
	qss_pkg::qss_pins_s pinOut, pinOe;
	logic queueRunEnable, queueDoneFlag, irqRequest, modeFault, haltAck;
	logic [3:0] completedQueuePointer, newQueuePointer;
	logic [31:0] r;
	int mismatches = 0, check_count = 0;

	always #20 sys_clk = ~sys_clk;

	qss_core qss_core_inst (.sys_clk, .rst, .masterSelect, .clockPolarity,
		.clockPhase, .transferBits, .wrapEnable, .wrapTargetSelect, .haltRequest,
		.queueDoneIrqEnable, .portDirection, .portValueWrite, .portValueData, .runEnableSet,
		.runEnableClear, .doneFlagClear, .modeFaultClear, .newQpWrite, .newQpData,
		.endQueuePointer, .txWrite, .txAddr, .txData, .cmdWrite, .cmdAddr, .cmdData, .rxAddr,
		.rxData, .sckIn, .mosiIn, .misoIn, .slaveSelectIn, .pinOut, .pinOe,
		.queueRunEnable, .queueDoneFlag, .irqRequest, .modeFault, .haltAck,
		.completedQueuePointer, .newQueuePointer);

	// an undriven data-out line floats high on its pull-up
	qss_far_master qss_far_master_inst (.sys_clk, .miso(pinOe.miso ? pinOut.miso : 1'h1),
		.sck(sckIn),
		.mosi(mosiIn), .selectN(slaveSelectIn));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("FAIL t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("checks=%0d mismatches=%0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	task automatic startQueue(input logic [3:0] qp, input logic run);
		@(negedge sys_clk) newQpWrite = 1'h1;
		newQpData = qp;
		runEnableSet = run;
		@(negedge sys_clk) newQpWrite = 1'h0;
		runEnableSet = 1'h0;
	endtask

	task automatic clearDone();
		@(negedge sys_clk) doneFlagClear = 1'h1;
		@(negedge sys_clk) doneFlagClear = 1'h0;
	endtask

	task automatic stopRun();
		@(negedge sys_clk) runEnableClear = 1'h1;
		@(negedge sys_clk) runEnableClear = 1'h0;
	endtask

	task automatic rxIs(input logic [3:0] a, input logic [15:0] exp);
		@(negedge sys_clk) rxAddr = a;
		tick(2);
		check(rxData, exp);
	endtask

	initial begin
		tick(8);
		rst = 1'h0;
		tick(3);
		check(pinOut.peripheral_select_pattern, 4'h0);
		for (int i = 0; i < 4; i++) begin
			@(negedge sys_clk) txWrite = 1'h1;
			txAddr = 4'(i);
			txData = TXV[i];
		end
		@(negedge sys_clk) txWrite = 1'h0;
		// plain slave queue of three bytes under one select
		startQueue(4'h0, 1'h1);
		tick(20);
		check(pinOe.sck, 1'h0);
		qss_far_master_inst.select(1'h1);
		for (int i = 0; i < 3; i++) begin
			qss_far_master_inst.xfer(8, 32'h30 + i, r);
			check(r, {24'h0, TXV[i][7:0]});
			check(completedQueuePointer, 4'(i));
			check({pinOe.sck, pinOe.peripheral_select_pattern}, 5'h00);
			rxIs(4'(i), 16'h0030 + 16'(i));
		end
		qss_far_master_inst.select(1'h0);
		check({queueDoneFlag, irqRequest, queueRunEnable}, 3'h6);
		tick(10);
		check(queueDoneFlag, 1'h1);
		clearDone();
		check({queueDoneFlag, irqRequest}, 2'h0);
		// 12-bit words, an aborted word, then a new pointer and a 32-bit burst
		transferBits = 4'hc;
		endQueuePointer = 4'h3;
		startQueue(4'h1, 1'h1);
		check(newQueuePointer, 4'h1);
		qss_far_master_inst.select(1'h1);
		qss_far_master_inst.xfer(5, 32'h1f, r);
		qss_far_master_inst.select(1'h0);
		qss_far_master_inst.select(1'h1);
		qss_far_master_inst.xfer(12, 32'h9c3, r);
		check(r, {20'h0, TXV[1][11:0]});
		rxIs(4'h1, 16'h09c3);
		qss_far_master_inst.select(1'h0);
		qss_far_master_inst.select(1'h1);
		qss_far_master_inst.xfer(12, 32'h5e1, r);
		check(completedQueuePointer, 4'h2);
		qss_far_master_inst.select(1'h0);
		transferBits = 4'h0;
		startQueue(4'h0, 1'h0);
		qss_far_master_inst.select(1'h1);
		qss_far_master_inst.xfer(32, 32'h1234abcd, r);
		check(r, {TXV[0], TXV[1]});
		check(completedQueuePointer, 4'h1);
		rxIs(4'h0, 16'h1234);
		check(queueRunEnable, 1'h1);
		qss_far_master_inst.select(1'h0);
		stopRun();
		// wraparound to zero, then to the new pointer, then wrap switched off
		transferBits = 4'h8;
		endQueuePointer = 4'h1;
		wrapEnable = 1'h1;
		startQueue(4'h0, 1'h1);
		qss_far_master_inst.select(1'h1);
		qss_far_master_inst.xfer(8, 32'h11, r);
		qss_far_master_inst.xfer(8, 32'h22, r);
		check({queueRunEnable, queueDoneFlag, irqRequest}, 3'h7);
		queueDoneIrqEnable = 1'h0;
		qss_far_master_inst.xfer(8, 32'h77, r);
		check(irqRequest, 1'h1);
		check(completedQueuePointer, 4'h0);
		rxIs(4'h0, 16'h0077);
		wrapTargetSelect = 1'h1;
		startQueue(4'h1, 1'h0);
		qss_far_master_inst.xfer(8, 32'h44, r);
		qss_far_master_inst.xfer(8, 32'h55, r);
		check(completedQueuePointer, 4'h1);
		wrapEnable = 1'h0;
		clearDone();
		qss_far_master_inst.xfer(8, 32'h66, r);
		check({queueRunEnable, queueDoneFlag, irqRequest}, 3'h2);
		check(completedQueuePointer, 4'h1);
		qss_far_master_inst.select(1'h0);
		// halt raised in mid-word
		endQueuePointer = 4'h3;
		startQueue(4'h0, 1'h1);
		qss_far_master_inst.select(1'h1);
		qss_far_master_inst.xfer(4, 32'h6, r);
		haltRequest = 1'h1;
		qss_far_master_inst.xfer(4, 32'h9, r);
		rxIs(4'h0, 16'h0069);
		qss_far_master_inst.xfer(8, 32'h5a, r);
		check({haltAck, completedQueuePointer}, 5'h10);
		qss_far_master_inst.select(1'h0);
		haltRequest = 1'h0;
		stopRun();
		clearDone();
		// one byte with the clock idling high and sampled on its trailing edge
		qss_far_master_inst.setMode(1'h1, 1'h1);
		clockPolarity = 1'h1;
		clockPhase = 1'h1;
		endQueuePointer = 4'h2;
		startQueue(4'h2, 1'h1);
		qss_far_master_inst.select(1'h1);
		qss_far_master_inst.xfer(8, 32'ha6, r);
		check(r, {24'h0, TXV[2][7:0]});
		rxIs(4'h2, 16'h00a6);
		check({queueRunEnable, queueDoneFlag}, 2'h1);
		qss_far_master_inst.select(1'h0);
		qss_far_master_inst.setMode(1'h0, 1'h0);
		clockPolarity = 1'h0;
		clockPhase = 1'h0;
		clearDone();
		// master mode chip-selects over an idle level of 1000
		@(negedge sys_clk) portValueWrite = 1'h1;
		portValueData = 4'h8;
		cmdWrite = 1'h1;
		cmdData = '{1'h0, 4'h7};
		@(negedge sys_clk) portValueWrite = 1'h0;
		cmdWrite = 1'h0;
		tick(2);
		check(pinOut.peripheral_select_pattern, 4'h8);
		masterSelect = 1'h1;
		misoIn = 1'h1;
		portDirection = 4'hf;
		endQueuePointer = 4'h0;
		startQueue(4'h0, 1'h1);
		for (int k = 0; k < 50 && pinOut.sck !== 1'h1; k++) @(negedge sys_clk);
		check(pinOut.peripheral_select_pattern, 4'h7);
		check(pinOut.mosi, TXV[0][7]);
		for (int k = 0; k < 200 && queueDoneFlag !== 1'h1; k++) @(negedge sys_clk);
		tick(4);
		check({queueRunEnable, pinOut.peripheral_select_pattern}, 5'h08);
		rxIs(4'h0, 16'h00ff);
		// select pulled low while master and its pin is an input
		portDirection = 4'he;
		qss_far_master_inst.select(1'h1);
		check(modeFault, 1'h1);
		check(pinOe, 7'h00);
		qss_far_master_inst.select(1'h0);
		@(negedge sys_clk) modeFaultClear = 1'h1;
		@(negedge sys_clk) modeFaultClear = 1'h0;
		check(modeFault, 1'h0);
		close_out();
	end

	// the sequence needs well under 10000 cycles
	initial begin
		tick(40000);
		mismatches++;
		close_out();
	end
endmodule // qss_core_test
`default_nettype wire

/* verification/qss_far_master.sv */
// external serial bus master driving the slave side of the queued serial port
`timescale 1ns/1ps
`default_nettype none
module qss_far_master #(
	parameter int HALF = 8
) (
	input wire logic sys_clk,
	input wire logic miso,
	output logic sck = 1'h0,
	output logic mosi = 1'h0,
	output logic selectN = 1'h1
);
	logic clock_polarity = 1'h0;
	logic clock_phase = 1'h0;

	task automatic wait_clk(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	// after release, mosi flips so a stale bit never looks valid
	task automatic select(input logic on);
		selectN = !on;
		wait_clk(HALF);
		if (!on) begin
			mosi = !mosi;
		end
	endtask

	// the idle level follows at once, so only call this while deselected
	task automatic setMode(input logic pol, input logic pha);
		clock_polarity = pol;
		clock_phase = pha;
		sck = pol;
	endtask

	// phase 0 sets data before the leading edge and samples on it;
	// phase 1 sets data on the leading edge and samples on the trailing one
	task automatic xfer(input int n, input logic [31:0] d, output logic [31:0] r);
		r = 32'h0;
		for (int i = n - 1; i >= 0; i--) begin
			sck = clock_phase ? !clock_polarity : clock_polarity;
			mosi = d[i];
			wait_clk(HALF);
			r = {r[30:0], miso};
			sck = clock_phase ? clock_polarity : !clock_polarity;
			wait_clk(HALF);
		end
		sck = clock_polarity;
	endtask
endmodule // qss_far_master
`default_nettype wire
